// ==== design/mbhr_regs.sv ====
// Holding-register bank of the drive serial slave
`timescale 1ns/10ps

module mbhr_regs #(
  parameter bit SAFETY_STOP = 1'b0
) (
  input  wire logic                                  core_clk,
  input  wire logic                                  rst_n,
  input  wire logic                                  req_valid,
  input  wire mbhr_pkg::mbhr_req_s                   req,
  output      logic                                  rsp_valid,
  output      logic [15:0]                           rsp_rdata,
  output      logic                                  rsp_hit,
  output      logic                                  rsp_bad_value,
  input  wire mbhr_pkg::mbhr_sts_s                   sts,
  input  wire logic                                  speed_unit,
  input  wire logic [15:0]                           out_speed,
  input  wire logic [15:0]                           set_speed,
  input  wire logic [mbhr_pkg::MON_N-1:0][15:0]      mon_vals,
  input  wire logic                                  opt_fitted,
  input  wire logic                                  panel_mode_valid,
  input  wire mbhr_pkg::mbhr_mode_e                  panel_mode,
  output      mbhr_pkg::mbhr_cmd_s                   cmd,
  output      logic [15:0]                           ctrl_word,
  output      logic [15:0]                           ctrl_eff,
  output      mbhr_pkg::mbhr_mode_e                  mode,
  output      logic [15:0]                           run_freq,
  output      logic                                  run_freq_rpm,
  output      logic                                  nv_wr,
  output      logic [15:0]                           nv_data
);

  // ----------------------------------------------------------
  // Decode
  // ----------------------------------------------------------
  function automatic logic [5:0] mon_lookup(input logic [16:0] n);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < mbhr_pkg::MON_N; i++)
      if (mbhr_pkg::MON_REGS[i] == n)
        r = {1'b1, 5'(i)};
    return r;
  endfunction

  function automatic logic [15:0] mode_code(input mbhr_pkg::mbhr_mode_e m);
    logic [15:0] c;
    c = 16'h0000;
    case (m)
      mbhr_pkg::MD_TERM:       c = 16'h0000;
      mbhr_pkg::MD_PANEL:      c = 16'h0001;
      mbhr_pkg::MD_TERM_INCH:  c = 16'h0002;
      mbhr_pkg::MD_PANEL_INCH: c = 16'h0003;
      mbhr_pkg::MD_LINK:       c = 16'h0004;
      mbhr_pkg::MD_PANEL_TERM: c = 16'h0005;
      default:                c = 16'h0000;
    endcase
    return c;
  endfunction

  logic [15:0]          ctrl_r;
  logic [15:0]          ctrl_eff_r;
  mbhr_pkg::mbhr_mode_e mode_r;
  mbhr_pkg::mbhr_mode_e mode_nxt;
  logic [15:0]          freq_r;
  logic                 rpm_r;
  logic                 nv_wr_r;
  logic [15:0]          nv_data_r;
  mbhr_pkg::mbhr_cmd_s  cmd_r;
  mbhr_pkg::mbhr_cmd_s  cmd_nxt;
  logic                 rsp_valid_r;
  logic [15:0]          rsp_rdata_r;
  logic                 rsp_hit_r;
  logic                 rsp_bad_r;

  wire [16:0] reg_num = 17'(req.addr) + mbhr_pkg::REG_BASE;
  wire        wr_acc  = req_valid & req.wr;
  wire        rd_acc  = req_valid & ~req.wr;
  wire [15:0] wd      = req.wdata;

  wire is_reset  = reg_num == mbhr_pkg::RG_RESET;
  wire is_clr    = reg_num == mbhr_pkg::RG_CLR;
  wire is_all    = reg_num == mbhr_pkg::RG_ALL_CLR;
  wire is_clr_kc = reg_num == mbhr_pkg::RG_CLR_KC;
  wire is_all_kc = reg_num == mbhr_pkg::RG_ALL_CLR_KC;
  wire is_ctrl   = reg_num == mbhr_pkg::RG_CTRL_STS;
  wire is_mode   = reg_num == mbhr_pkg::RG_MODE;
  wire is_freq   = reg_num == mbhr_pkg::RG_FREQ_RAM;
  wire is_fnv    = reg_num == mbhr_pkg::RG_FREQ_NV;
  wire [5:0] mon = mon_lookup(reg_num);
  wire       mon_hit = mon[5];
  wire [4:0] mon_i   = mon[4:0];

  wire key_clr    = is_clr & (wd == mbhr_pkg::KEY_CLR);
  wire key_all    = is_all & (wd == mbhr_pkg::KEY_ALL_CLR);
  wire key_clr_kc = is_clr_kc & (wd == mbhr_pkg::KEY_CLR_KC);
  wire key_all_kc = is_all_kc & (wd == mbhr_pkg::KEY_ALL_CLR_KC);
  wire is_keyed   = is_clr | is_all | is_clr_kc | is_all_kc;
  wire key_ok     = key_clr | key_all | key_clr_kc | key_all_kc;

  wire mode_term = is_mode & (wd == mbhr_pkg::MODE_WR_TERM);
  wire mode_link = is_mode & (wd == mbhr_pkg::MODE_WR_LINK);
  wire bad_val  = (is_keyed & ~key_ok) | (is_mode & ~mode_term & ~mode_link);

  // write-only and unknown registers have no read path
  wire wr_hit = is_reset | is_keyed | is_ctrl | is_mode | is_freq | is_fnv;
  wire rd_hit = is_ctrl | is_mode | is_freq | mon_hit;

  // ----------------------------------------------------------
  // Read data
  // ----------------------------------------------------------
  // status word, other bits zero
  // bits 0, 6, 7 arrive already routed by the output map
  wire [15:0] sts_word = {sts.fault_occ, 7'h00, sts.fault_relay,
                          sts.freq_threshold_flag, 1'b0, sts.overload_flag,
                          sts.at_target_freq, sts.rev, sts.fwd, sts.running};

  wire [15:0] mon_raw = mon_vals[mon_i];
  wire is_fmon = (mon_i == mbhr_pkg::MI_OUT_FREQ) |
                 (mon_i == mbhr_pkg::MI_SET_FREQ);
  wire [15:0] fmon = (mon_i == mbhr_pkg::MI_OUT_FREQ) ? out_speed : set_speed;
  wire is_opt = (mon_i == mbhr_pkg::MI_OPT_IN1) |
                (mon_i == mbhr_pkg::MI_OPT_IN2) |
                (mon_i == mbhr_pkg::MI_OPT_OUT);
  // inhibit input forced off on safety-stop variants
  wire [15:0] inh_mask = SAFETY_STOP ?
                         ~(16'h0001 << mbhr_pkg::IN_TERM_INHIBIT_BIT) :
                         16'hFFFF;
  wire [15:0] mon_rd = (is_fmon & speed_unit) ? fmon :
                       (is_opt & ~opt_fitted) ? 16'h0000 :
                       (mon_i == mbhr_pkg::MI_IN_TERM) ? (mon_raw & inh_mask) :
                       mon_raw;

  // read of control register returns status
  wire [15:0] rd_val = is_ctrl ? sts_word :
                       is_mode ? mode_code(mode_r) :
                       is_freq ? freq_r :
                       mon_hit ? mon_rd : 16'h0000;

  // ----------------------------------------------------------
  // Commands
  // ----------------------------------------------------------
  // any value resets the drive
  // second pair flags communication settings as kept
  assign cmd_nxt.drive_reset     = wr_acc & is_reset;
  assign cmd_nxt.param_clear     = wr_acc & (key_clr | key_clr_kc);
  assign cmd_nxt.all_param_clear = wr_acc & (key_all | key_all_kc);
  assign cmd_nxt.keep_comm       = wr_acc & (key_clr_kc | key_all_kc);

  // bus write beats a panel request in the same cycle
  assign mode_nxt = (wr_acc & mode_link) ? mbhr_pkg::MD_LINK :
                    (wr_acc & mode_term) ? mbhr_pkg::MD_TERM :
                    panel_mode_valid   ? panel_mode : mode_r;

  // ----------------------------------------------------------
  // Registers
  // ----------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cmd_r       <= '0;
      ctrl_r      <= mbhr_pkg::CTRL_RST;
      ctrl_eff_r  <= mbhr_pkg::CTRL_RST;
      mode_r      <= mbhr_pkg::MODE_RST;
      freq_r      <= mbhr_pkg::RUN_FREQ_RST;
      rpm_r       <= 1'b0;
      nv_wr_r     <= 1'b0;
      nv_data_r   <= mbhr_pkg::RUN_FREQ_RST;
      rsp_valid_r <= 1'b0;
      rsp_rdata_r <= 16'h0000;
      rsp_hit_r   <= 1'b0;
      rsp_bad_r   <= 1'b0;
    end
    else
    begin
      cmd_r       <= cmd_nxt;
      mode_r      <= mode_nxt;
      // unused control bits stored as zero
      // default bit meanings kept in place
      if (wr_acc & is_ctrl)
        ctrl_r <= wd & mbhr_pkg::CTRL_USED_MASK;
      // command bits act only in fieldbus mode
      ctrl_eff_r  <= (mode_r == mbhr_pkg::MD_LINK) ? ctrl_r : 16'h0000;
      if (wr_acc & is_freq)
        freq_r <= wd;
      // frequency unit follows the display setting
      rpm_r       <= speed_unit;
      // non-volatile store is a write strobe
      nv_wr_r     <= wr_acc & is_fnv;
      if (wr_acc & is_fnv)
        nv_data_r <= wd;
      rsp_valid_r <= req_valid;
      rsp_rdata_r <= rd_acc ? rd_val : 16'h0000;
      rsp_hit_r   <= req_valid & (req.wr ? wr_hit : rd_hit);
      rsp_bad_r   <= wr_acc & bad_val;
    end
  end

  assign cmd           = cmd_r;
  assign ctrl_word     = ctrl_r;
  assign ctrl_eff      = ctrl_eff_r;
  assign mode          = mode_r;
  assign run_freq      = freq_r;
  assign run_freq_rpm  = rpm_r;
  assign nv_wr         = nv_wr_r;
  assign nv_data       = nv_data_r;
  assign rsp_valid     = rsp_valid_r;
  assign rsp_rdata     = rsp_rdata_r;
  assign rsp_hit       = rsp_hit_r;
  assign rsp_bad_value = rsp_bad_r;

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  reset_pulse_a: assert property (
    wr_acc && is_reset |=> cmd.drive_reset ##1 !cmd.drive_reset || $past(wr_acc && is_reset))
    else $error("drive reset pulse missing");

  clear_key_a: assert property (
    cmd.param_clear && !cmd.keep_comm |->
      $past(req.wdata) == mbhr_pkg::KEY_CLR)
    else $error("parameter clear without key");

  all_key_a: assert property (
    cmd.all_param_clear && !cmd.keep_comm |->
      $past(req.wdata) == mbhr_pkg::KEY_ALL_CLR)
    else $error("all clear without key");

  keep_comm_a: assert property (
    wr_acc && (key_clr_kc || key_all_kc) |=>
      cmd.keep_comm && (cmd.param_clear || cmd.all_param_clear))
    else $error("keep-comm clear wrong");

  wrong_key_a: assert property (
    wr_acc && is_keyed && !key_ok |=>
      !cmd.param_clear && !cmd.all_param_clear && rsp_bad_value)
    else $error("wrong key started clear");

  status_read_a: assert property (
    rd_acc && is_ctrl |=> rsp_rdata == {$past(sts.fault_occ), 7'h00,
      $past(sts.fault_relay), $past(sts.freq_threshold_flag), 1'b0,
      $past(sts.overload_flag), $past(sts.at_target_freq),
      $past(sts.rev), $past(sts.fwd), $past(sts.running)})
    else $error("status word mismatch");

  mode_link_a: assert property (
    wr_acc && mode_link |=> mode == mbhr_pkg::MD_LINK)
    else $error("fieldbus mode not taken");

  freq_back_a: assert property (
    wr_acc && is_freq ##1 !(wr_acc && is_freq) ##1 rd_acc && is_freq |=>
      rsp_rdata == $past(req.wdata, 3))
    else $error("frequency readback wrong");

  unmapped_zero_a: assert property (
    rd_acc && !rd_hit |=> rsp_valid && !rsp_hit && rsp_rdata == 16'h0000)
    else $error("unmapped read not zero");

  option_off_a: assert property (
    rd_acc && mon_hit && is_opt && !opt_fitted |=> rsp_rdata == 16'h0000)
    else $error("option monitor not blank");

  ctrl_gate_a: assert property (
    mode != mbhr_pkg::MD_LINK |=> ctrl_eff == 16'h0000)
    else $error("control active outside fieldbus");

  nv_pulse_a: assert property (
    wr_acc && is_fnv |=> nv_wr && nv_data == $past(req.wdata))
    else $error("non-volatile write lost");

  ctrl_mask_a: assert property (
    wr_acc && is_ctrl |=> (ctrl_word & ~mbhr_pkg::CTRL_USED_MASK) == 16'h0000
      && ctrl_word[2:0] == $past(req.wdata[2:0]))
    else $error("control word mask wrong");

  bad_mode_a: assert property (
    wr_acc && is_mode && !mode_term && !mode_link && !panel_mode_valid |=>
      mode == $past(mode) && rsp_bad_value)
    else $error("undefined mode value taken");

  mode_read_a: assert property (
    rd_acc && is_mode && mode == mbhr_pkg::MD_LINK |=>
      rsp_rdata == 16'h0004)
    else $error("fieldbus mode code wrong");

  inhibit_off_a: assert property (
    SAFETY_STOP && rd_acc && mon_hit && mon_i == mbhr_pkg::MI_IN_TERM |=>
      !rsp_rdata[mbhr_pkg::IN_TERM_INHIBIT_BIT])
    else $error("inhibit input bit not off");

  speed_mon_a: assert property (
    rd_acc && mon_hit && mon_i == mbhr_pkg::MI_OUT_FREQ && speed_unit |=>
      rsp_rdata == $past(out_speed))
    else $error("speed monitor wrong");

  rpm_follow_a: assert property (
    speed_unit != run_freq_rpm |=> run_freq_rpm == $past(speed_unit))
    else $error("speed unit flag lags");

endmodule

// ==== design/mbhr_pkg.sv ====
// Constants, types and register map of the holding-register bank
package mbhr_pkg;

  // Register numbers; protocol address is register number minus base
  localparam logic [16:0] REG_BASE      = 17'h09C41;
  localparam logic [16:0] RG_RESET      = 17'h09C42;
  localparam logic [16:0] RG_CLR        = 17'h09C43;
  localparam logic [16:0] RG_ALL_CLR    = 17'h09C44;
  localparam logic [16:0] RG_CLR_KC     = 17'h09C46;
  localparam logic [16:0] RG_ALL_CLR_KC = 17'h09C47;
  localparam logic [16:0] RG_CTRL_STS   = 17'h09C49;
  localparam logic [16:0] RG_MODE       = 17'h09C4A;
  localparam logic [16:0] RG_FREQ_RAM   = 17'h09C4E;
  localparam logic [16:0] RG_FREQ_NV    = 17'h09C4F;

  // Clear keys
  localparam logic [15:0] KEY_CLR       = 16'h965A;
  localparam logic [15:0] KEY_ALL_CLR   = 16'h99AA;
  localparam logic [15:0] KEY_CLR_KC    = 16'h5A96;
  localparam logic [15:0] KEY_ALL_CLR_KC = 16'hAA99;

  // Mode write values
  localparam logic [15:0] MODE_WR_TERM  = 16'h0010;
  localparam logic [15:0] MODE_WR_LINK  = 16'h0014;

  // Control bits in use: 0-5, 7, 8, 10, 12
  localparam logic [15:0] CTRL_USED_MASK = 16'h15BF;
  localparam logic [15:0] CTRL_RST       = 16'h0000;
  localparam logic [15:0] RUN_FREQ_RST   = 16'h0000;

  // Output-inhibit bit inside the input terminal monitor
  localparam int          IN_TERM_INHIBIT_BIT = 6;

  // Monitor bank, in index order
  localparam int          MON_N = 26;
  localparam logic [16:0] MON_REGS [MON_N] = '{
    17'h09D09, 17'h09D0A, 17'h09D0B, 17'h09D0D, 17'h09D0F, 17'h09D10,
    17'h09D11, 17'h09D12, 17'h09D13, 17'h09D14, 17'h09D16, 17'h09D17,
    17'h09D18, 17'h09D1C, 17'h09D1F, 17'h09D20, 17'h09D21, 17'h09D3C,
    17'h09D3D, 17'h09D3E, 17'h09D42, 17'h09D43, 17'h09D44, 17'h09D45,
    17'h09D46, 17'h09D47};
  localparam logic [4:0]  MI_OUT_FREQ = 5'h00;
  localparam logic [4:0]  MI_SET_FREQ = 5'h03;
  localparam logic [4:0]  MI_IN_TERM  = 5'h0B;
  localparam logic [4:0]  MI_OPT_IN1  = 5'h14;
  localparam logic [4:0]  MI_OPT_IN2  = 5'h15;
  localparam logic [4:0]  MI_OPT_OUT  = 5'h16;

  typedef enum logic [2:0] {
    MD_TERM, MD_PANEL, MD_TERM_INCH, MD_PANEL_INCH, MD_LINK, MD_PANEL_TERM
  } mbhr_mode_e;

  localparam mbhr_mode_e MODE_RST = MD_TERM;

  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mbhr_req_s;

  typedef struct packed {
    logic running;
    logic fwd;
    logic rev;
    logic at_target_freq;
    logic overload_flag;
    logic freq_threshold_flag;
    logic fault_relay;
    logic fault_occ;
  } mbhr_sts_s;

  typedef struct packed {
    logic drive_reset;
    logic param_clear;
    logic all_param_clear;
    logic keep_comm;
  } mbhr_cmd_s;

endpackage

// ==== verif/mbhr_master.sv ====
// Serial master model issuing single-word register requests
`timescale 1ns/10ps

module mbhr_master (
  input  wire logic                core_clk,
  output      logic                req_valid,
  output      mbhr_pkg::mbhr_req_s req,
  input  wire logic                rsp_valid,
  input  wire logic [15:0]         rsp_rdata,
  input  wire logic                rsp_hit,
  input  wire logic                rsp_bad_value
);
  // ----------------------------------------------------------------
  // Request task
  // ----------------------------------------------------------------
  initial
  begin
    req_valid = 1'b0;
    req       = '0;
  end

  task automatic xfer(input  logic        wr,
                      input  logic [16:0] rg,
                      input  logic [15:0] wd,
                      output logic [15:0] rd,
                      output logic        hit,
                      output logic        bad,
                      output logic        ok);
    @(posedge core_clk);
    #1;
    req_valid = 1'b1;
    req.wr    = wr;
    req.addr  = 16'(rg - mbhr_pkg::REG_BASE);
    req.wdata = wd;
    @(posedge core_clk);
    #1;
    req_valid = 1'b0;
    // Released lines must not keep the old value
    req       = ~req;
    ok        = rsp_valid;
    rd        = rsp_rdata;
    hit       = rsp_hit;
    bad       = rsp_bad_value;
  endtask
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the holding-register bank
`timescale 1ns/10ps

module testbench;
  typedef struct {
    logic        wr;
    logic [16:0] rg;
    logic [15:0] wd;
    logic [15:0] rd;
    logic        hit;
    logic        bad;
    logic [3:0]  cmd;
  } mbhr_row_s;

  logic                             core_clk;
  logic                             rst_n;
  logic                             req_valid;
  mbhr_pkg::mbhr_req_s              req;
  logic                             rsp_valid;
  logic [15:0]                      rsp_rdata;
  logic                             rsp_hit;
  logic                             rsp_bad_value;
  mbhr_pkg::mbhr_sts_s              sts;
  logic                             speed_unit;
  logic                             opt_fitted;
  logic                             panel_mode_valid;
  mbhr_pkg::mbhr_mode_e             panel_mode;
  logic [mbhr_pkg::MON_N-1:0][15:0] mon_vals;
  mbhr_pkg::mbhr_cmd_s              cmd;
  logic [15:0]                      ctrl_word;
  logic [15:0]                      ctrl_eff;
  mbhr_pkg::mbhr_mode_e             mode;
  logic [15:0]                      run_freq;
  logic                             run_freq_rpm;
  logic                             nv_wr;
  logic [15:0]                      nv_data;
  logic [15:0]                      rd;
  logic                             hit;
  logic                             bad;
  logic                             ok;
  int                               n_fail;
  int                               checks;
  int                               cyc;
  mbhr_row_s                        rows [14];

  mbhr_regs #(.SAFETY_STOP(1'b1)) u_mbhr_regs (
    .core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_hit(rsp_hit),
    .rsp_bad_value(rsp_bad_value), .sts(sts), .speed_unit(speed_unit),
    .out_speed(16'h0BB8), .set_speed(16'h0578), .mon_vals(mon_vals),
    .opt_fitted(opt_fitted), .panel_mode_valid(panel_mode_valid),
    .panel_mode(panel_mode), .cmd(cmd), .ctrl_word(ctrl_word),
    .ctrl_eff(ctrl_eff), .mode(mode), .run_freq(run_freq),
    .run_freq_rpm(run_freq_rpm), .nv_wr(nv_wr), .nv_data(nv_data));

  mbhr_master u_mbhr_master (
    .core_clk(core_clk), .req_valid(req_valid), .req(req),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_hit(rsp_hit),
    .rsp_bad_value(rsp_bad_value));

  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Whole run needs well under 1000 cycles
  always @(posedge core_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      n_fail = n_fail + 1;
      $display("mismatch at %0t: timeout", $time);
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, exp, input string msg);
    checks = checks + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic acc(input logic wr, input logic [16:0] rg,
                     input logic [15:0] wd);
    u_mbhr_master.xfer(wr, rg, wd, rd, hit, bad, ok);
    chk({15'h0, ok}, 16'h0001, "no answer");
  endtask

  function automatic logic [15:0] sts_exp(mbhr_pkg::mbhr_sts_s s);
    return {s.fault_occ, 7'h00, s.fault_relay, s.freq_threshold_flag, 1'b0,
            s.overload_flag, s.at_target_freq, s.rev, s.fwd, s.running};
  endfunction

  function automatic logic [15:0] mon_exp(int i, logic su, logic opt);
    logic [15:0] v;
    v = 16'hA5C0 ^ 16'(i);
    if (su && i == 0) v = 16'h0BB8;
    if (su && i == 3) v = 16'h0578;
    if (!opt && i >= 20 && i <= 22) v = 16'h0000;
    if (i == 11) v[6] = 1'b0;
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    n_fail = 0;
    checks = 0;
    cyc = 0;
    rst_n = 1'b0;
    sts = '0;
    speed_unit = 1'b0;
    opt_fitted = 1'b0;
    panel_mode_valid = 1'b0;
    panel_mode = mbhr_pkg::MD_TERM;
    for (int i = 0; i < mbhr_pkg::MON_N; i++) mon_vals[i] = 16'hA5C0 ^ 16'(i);
    rows = '{
      '{1, mbhr_pkg::RG_RESET, 16'h1234, 16'h0, 1, 0, 4'h8},
      '{1, mbhr_pkg::RG_CLR, 16'h965A, 16'h0, 1, 0, 4'h4},
      '{1, mbhr_pkg::RG_CLR, 16'h5A96, 16'h0, 1, 1, 4'h0},
      '{1, mbhr_pkg::RG_ALL_CLR, 16'h99AA, 16'h0, 1, 0, 4'h2},
      '{1, mbhr_pkg::RG_ALL_CLR, 16'h965A, 16'h0, 1, 1, 4'h0},
      '{1, mbhr_pkg::RG_CLR_KC, 16'h5A96, 16'h0, 1, 0, 4'h5},
      '{1, mbhr_pkg::RG_ALL_CLR_KC, 16'hAA99, 16'h0, 1, 0, 4'h3},
      '{1, mbhr_pkg::RG_ALL_CLR_KC, 16'h99AA, 16'h0, 1, 1, 4'h0},
      '{0, mbhr_pkg::RG_RESET, 16'h0, 16'h0, 0, 0, 4'h0},
      '{1, 17'h09C45, 16'hBEEF, 16'h0, 0, 0, 4'h0},
      '{0, 17'h09C45, 16'h0, 16'h0, 0, 0, 4'h0},
      '{1, mbhr_pkg::RG_FREQ_RAM, 16'h1770, 16'h0, 1, 0, 4'h0},
      '{0, mbhr_pkg::RG_FREQ_RAM, 16'h0, 16'h1770, 1, 0, 4'h0},
      '{1, 17'h09D13, 16'h0055, 16'h0, 0, 0, 4'h0}};
    repeat (20) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    chk({13'h0, mode}, 16'h0000, "reset mode");
    chk(ctrl_word, 16'h0000, "reset control");
    $display("test reset done");
    for (int r = 0; r < 14; r++)
    begin
      acc(rows[r].wr, rows[r].rg, rows[r].wd);
      chk(rd, rows[r].rd, "row data");
      chk({15'h0, hit}, {15'h0, rows[r].hit}, "row hit");
      chk({15'h0, bad}, {15'h0, rows[r].bad}, "row refused");
      chk({12'h0, cmd}, {12'h0, rows[r].cmd}, "row command");
    end
    $display("test rows done");
    acc(1'b1, mbhr_pkg::RG_FREQ_NV, 16'h0BB8);
    chk({15'h0, nv_wr}, 16'h0001, "nv strobe");
    chk(run_freq, 16'h1770, "nv keeps volatile");
    chk(nv_data, 16'h0BB8, "nv data");
    acc(1'b0, mbhr_pkg::RG_FREQ_NV, 16'h0);
    chk({15'h0, hit}, 16'h0000, "nv read");
    $display("test frequency done");
    acc(1'b1, mbhr_pkg::RG_CTRL_STS, 16'hFFFF);
    chk(ctrl_word, 16'h15BF, "control mask");
    chk(ctrl_eff, 16'h0000, "control outside link");
    for (int k = 0; k < 2; k++)
    begin
      sts = (k == 0) ? 8'hA5 : 8'h5A;
      acc(1'b0, mbhr_pkg::RG_CTRL_STS, 16'h0);
      chk(rd, sts_exp(sts), "status word");
    end
    $display("test control done");
    acc(1'b1, mbhr_pkg::RG_MODE, 16'h0014);
    @(posedge core_clk);
    #1;
    chk(ctrl_eff, 16'h15BF, "control on link");
    acc(1'b0, mbhr_pkg::RG_MODE, 16'h0);
    chk(rd, 16'h0004, "link mode");
    acc(1'b1, mbhr_pkg::RG_MODE, 16'h0011);
    chk({15'h0, bad}, 16'h0001, "bad mode");
    chk({13'h0, mode}, 16'h0004, "mode kept");
    acc(1'b1, mbhr_pkg::RG_MODE, 16'h0010);
    chk({13'h0, mode}, 16'h0000, "terminal mode");
    for (int m = 0; m < 6; m++)
    begin
      @(posedge core_clk);
      #1;
      panel_mode_valid = 1'b1;
      panel_mode = mbhr_pkg::mbhr_mode_e'(m);
      @(posedge core_clk);
      #1;
      panel_mode_valid = 1'b0;
      acc(1'b0, mbhr_pkg::RG_MODE, 16'h0);
      chk(rd, 16'(m), "mode code");
    end
    $display("test mode done");
    for (int p = 0; p < 2; p++)
    begin
      speed_unit = p[0];
      opt_fitted = p[0];
      for (int i = 0; i < mbhr_pkg::MON_N; i++)
      begin
        acc(1'b0, mbhr_pkg::MON_REGS[i], 16'h0);
        chk(rd, mon_exp(i, p[0], p[0]), "monitor");
      end
      chk({15'h0, run_freq_rpm}, 16'(p), "speed unit");
    end
    $display("test monitors done");
    @(posedge core_clk);
    #1;
    rst_n = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    chk({13'h0, mode}, 16'h0000, "reset mode again");
    chk(ctrl_word, 16'h0000, "reset control again");
    chk(run_freq, 16'h0000, "reset frequency");
    acc(1'b0, mbhr_pkg::RG_MODE, 16'h0);
    chk(rd, 16'h0000, "mode code after reset");
    $display("test reset again done");
    test_done();
  end
endmodule
